// ### qlps_link_partner.sv
// Link partner model that drives the physical receive lanes of all pairs.
`timescale 1ns/1ps
module qlps_link_partner (
  input  wire logic                                        clock,
  output qlps_pkg::qlps_lanes_t [qlps_pkg::PAIR_COUNT-1:0] rxLaneData
);
  logic [7:0] seq_r;

  // ---------------------------------------------------------------
  // Receive lane drive
  // ---------------------------------------------------------------
  // Every lane gets a fresh word each cycle, so a stale, swapped or stuck lane differs at once.
  // One process owns the lanes; each pair also differs on C and D, so a pair swap shows there too.
  initial begin
    seq_r = 8'h01;
    rxLaneData = '0;
    forever begin
      @(negedge clock);
      for (int p = 0; p < qlps_pkg::PAIR_COUNT; p++) begin
        rxLaneData[p] = {seq_r ^ 8'(p), ~seq_r ^ 8'(p), seq_r + 8'(8'h40 + p), seq_r ^ 8'(8'hA5 + p)};
      end
      seq_r = seq_r + 8'h01;
    end
  end
endmodule

// ### qlps_pkg.sv
// Shared types and constants for the quad lane port steering block.
package qlps_pkg;

  // ---------------------------------------------------------------
  // Sizes and port numbering
  // ---------------------------------------------------------------
  localparam int PAIR_COUNT = 4;
  localparam int PORT_COUNT = 8;
  localparam int FIRST_PORT = 0;
  localparam int LAST_PORT  = 7;

  // Lane words are numbered with bit 0 as the most significant bit.
  localparam int WORD_FIRST_BIT = 0;
  localparam int WORD_LAST_BIT  = 7;

  // ---------------------------------------------------------------
  // Startup sampling of the lane mode select pins
  // ---------------------------------------------------------------
  localparam int          MODE_HOLD_CYCLES = 10;
  localparam logic [3:0]  SAMPLE_AT        = 4'(MODE_HOLD_CYCLES - 1);
  localparam logic [3:0]  COUNT_RESET      = 4'h0;
  localparam logic [3:0]  COUNT_STEP       = 4'h1;

  // Select level: low gives four lanes to the even port.
  localparam logic MODE_FOUR_LANE   = 1'b0;
  localparam logic MODE_SINGLE_LANE = 1'b1;

  typedef logic [WORD_FIRST_BIT:WORD_LAST_BIT] qlps_word_t;

  localparam qlps_word_t IDLE_WORD = 8'h00;

  // One group of four lanes, A to D.
  typedef struct packed {
    qlps_word_t a;
    qlps_word_t b;
    qlps_word_t c;
    qlps_word_t d;
  } qlps_lanes_t;

  localparam qlps_lanes_t IDLE_LANES = '{a: IDLE_WORD, b: IDLE_WORD, c: IDLE_WORD, d: IDLE_WORD};

  typedef enum logic {
    QLPS_SAMPLING,
    QLPS_RUNNING
  } qlps_state_t;

endpackage

// ### qlps_quad_lane_port_steering.sv
// Lane steering between four-lane and single-lane ports for four port pairs.
`timescale 1ns/1ps
// How it works
// R01: The eight ports are numbered 0 to 7, pair p owning ports 2p and 2p+1, and these indices name the port arrays.
// R02: Each even port may run four lanes or one lane while its odd partner only ever runs one lane.
// R03: Transmit lane A always carries the even port's lane A data.
// R04: Transmit lane B carries the even port's lane B in four-lane mode and the odd port's data in single-lane mode.
// R05: Receive lane B goes to the even port in four-lane mode and to the odd port in single-lane mode.
// R06: Transmit lanes C and D carry even port data only in four-lane mode.
// R07: Receive lanes C and D reach the even port only in four-lane mode.
// R08: Every lane word is indexed 0 to 7 with bit 0 the most significant bit.
// R09: A low mode select gives the even port four lanes and the odd port none, a high one gives both one lane.
// R10: The mode select is sampled once inside the ten cycles after reset release and ignored afterwards.
// R11: In four-lane mode the odd port is never used and is held powered down.
// R12: In single-lane mode lanes C and D carry nothing: transmit is idle and received data is dropped.
module qlps_quad_lane_port_steering (
  input  wire logic                                        clock,
  input  wire logic                                        rst_n,
  input  wire logic        [qlps_pkg::PAIR_COUNT-1:0]      lane_mode_select,
  input  wire qlps_pkg::qlps_lanes_t [qlps_pkg::PORT_COUNT-1:0] txPortData,
  input  wire qlps_pkg::qlps_lanes_t [qlps_pkg::PAIR_COUNT-1:0] rxLaneData,
  output logic                                             modeValid,
  output logic             [qlps_pkg::PAIR_COUNT-1:0]      pairSingleLane,
  output logic             [qlps_pkg::PORT_COUNT-1:0]      port_power_down,
  output qlps_pkg::qlps_lanes_t [qlps_pkg::PAIR_COUNT-1:0] txLaneData,
  output qlps_pkg::qlps_lanes_t [qlps_pkg::PORT_COUNT-1:0] rxPortData
);

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  // Decodes a sampled select level; used by the steering and the checks.
  function automatic logic isFourLane(input logic modeBit);
    isFourLane = (modeBit == qlps_pkg::MODE_FOUR_LANE);
  endfunction

  // -------------------------------------------------------------
  // Mode select synchroniser and startup sampling
  // -------------------------------------------------------------
  logic [qlps_pkg::PAIR_COUNT-1:0] syncA_r, syncA_nxt;
  logic [qlps_pkg::PAIR_COUNT-1:0] syncB_r, syncB_nxt;
  logic [qlps_pkg::PAIR_COUNT-1:0] mode_r, mode_nxt;
  logic [3:0]                      count_r, count_nxt;
  qlps_pkg::qlps_state_t           state_r, state_nxt;

  // The pins are board straps from outside this clock domain, so they pass two flops first.
  always_comb begin
    syncA_nxt = lane_mode_select;
    syncB_nxt = syncA_r;
    count_nxt = count_r;
    mode_nxt  = mode_r;
    state_nxt = state_r;
    unique case (state_r)
      qlps_pkg::QLPS_SAMPLING: begin
        count_nxt = count_r + qlps_pkg::COUNT_STEP;
        // Sampling late in the hold window leaves the two sync stages time to settle.
        if (count_r == qlps_pkg::SAMPLE_AT) begin // R10
          mode_nxt  = syncB_r; // R09
          state_nxt = qlps_pkg::QLPS_RUNNING;
        end
      end
      qlps_pkg::QLPS_RUNNING: begin
        // Further pin changes are ignored until the next reset.
        count_nxt = count_r; // R10
      end
    endcase
  end

  // Registers only; the reset is synchronous.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncA_r <= '0;
      syncB_r <= '0;
      mode_r  <= '0;
      count_r <= qlps_pkg::COUNT_RESET;
      state_r <= qlps_pkg::QLPS_SAMPLING;
    end else begin
      syncA_r <= syncA_nxt;
      syncB_r <= syncB_nxt;
      mode_r  <= mode_nxt;
      count_r <= count_nxt;
      state_r <= state_nxt;
    end
  end

  // -------------------------------------------------------------
  // Lane steering
  // -------------------------------------------------------------
  logic                                            modeValid_nxt;
  logic                  [qlps_pkg::PAIR_COUNT-1:0] pairSingleLane_nxt;
  logic                  [qlps_pkg::PORT_COUNT-1:0] powerDown_nxt;
  qlps_pkg::qlps_lanes_t [qlps_pkg::PAIR_COUNT-1:0] txLane_nxt;
  qlps_pkg::qlps_lanes_t [qlps_pkg::PORT_COUNT-1:0] rxPort_nxt;

  // Until the mode is known every lane is idle and every port is powered down,
  // so no traffic is ever sent on a lane that turns out to be unowned.
  always_comb begin
    modeValid_nxt      = (state_r == qlps_pkg::QLPS_RUNNING);
    pairSingleLane_nxt = mode_r;
    powerDown_nxt      = '1;
    txLane_nxt         = {qlps_pkg::PAIR_COUNT{qlps_pkg::IDLE_LANES}};
    rxPort_nxt         = {qlps_pkg::PORT_COUNT{qlps_pkg::IDLE_LANES}};
    if (modeValid_nxt) begin
      for (int p = 0; p < qlps_pkg::PAIR_COUNT; p++) begin
        // Even port 2p owns lanes A to D, odd port 2p+1 borrows lane B.
        txLane_nxt[p].a    = txPortData[2*p].a; // R01 R03 R08
        rxPort_nxt[2*p].a  = rxLaneData[p].a;
        powerDown_nxt[2*p] = 1'b0; // R02
        if (isFourLane(mode_r[p])) begin
          txLane_nxt[p].b      = txPortData[2*p].b; // R04
          txLane_nxt[p].c      = txPortData[2*p].c; // R06
          txLane_nxt[p].d      = txPortData[2*p].d; // R06
          rxPort_nxt[2*p].b    = rxLaneData[p].b; // R05
          rxPort_nxt[2*p].c    = rxLaneData[p].c; // R07
          rxPort_nxt[2*p].d    = rxLaneData[p].d; // R07
          powerDown_nxt[2*p+1] = 1'b1; // R11
        end else begin
          // Lanes C and D stay idle and their receive data is dropped.
          txLane_nxt[p].b      = txPortData[2*p+1].a; // R04 R12
          rxPort_nxt[2*p+1].a  = rxLaneData[p].b; // R05
          powerDown_nxt[2*p+1] = 1'b0; // R02
        end
      end
    end
  end

  // Every output is a flop, which costs one cycle of lane latency.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      modeValid       <= 1'b0;
      pairSingleLane  <= '0;
      port_power_down <= '1;
      txLaneData      <= {qlps_pkg::PAIR_COUNT{qlps_pkg::IDLE_LANES}};
      rxPortData      <= {qlps_pkg::PORT_COUNT{qlps_pkg::IDLE_LANES}};
    end else begin
      modeValid       <= modeValid_nxt;
      pairSingleLane  <= pairSingleLane_nxt;
      port_power_down <= powerDown_nxt;
      txLaneData      <= txLane_nxt;
      rxPortData      <= rxPort_nxt;
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  // A cycle counter since reset release bounds the sampling moment.
  logic [4:0] sinceReset_r, sinceReset_nxt;

  // The counter parks at its top value, so a long run never wraps back into the window.
  always_comb begin
    sinceReset_nxt = sinceReset_r;
    if (sinceReset_r != '1) begin
      sinceReset_nxt = sinceReset_r + 5'h01;
    end
  end

  // Registers only; cleared by the same synchronous reset as the logic it watches.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sinceReset_r <= '0;
    end else begin
      sinceReset_r <= sinceReset_nxt;
    end
  end

  sample_window_a: assert property (@(posedge clock) disable iff (!rst_n) // R10
    (sinceReset_r == 5'(qlps_pkg::MODE_HOLD_CYCLES + 1)) |-> modeValid)
    else $error("Mode was not valid right after the hold window.");

  mode_frozen_a: assert property (@(posedge clock) disable iff (!rst_n) // R10
    ($past(modeValid) && modeValid) |-> $stable(pairSingleLane))
    else $error("Sampled mode changed after startup.");

  idle_before_a: assert property (@(posedge clock) disable iff (!rst_n) // lanes idle and ports powered down until the mode is sampled
    !modeValid |-> (port_power_down == '1 && txLaneData == {qlps_pkg::PAIR_COUNT{qlps_pkg::IDLE_LANES}}))
    else $error("Lanes active before the mode was sampled.");

  for (genvar p = 0; p < qlps_pkg::PAIR_COUNT; p++) begin : g_chk
    lane_a_tx_a: assert property (@(posedge clock) disable iff (!rst_n) // R03
      (modeValid && $past(modeValid)) |-> txLaneData[p].a == $past(txPortData[2*p].a))
      else $error("Transmit lane A does not carry the even port.");

    lane_b_tx_a: assert property (@(posedge clock) disable iff (!rst_n) // R04
      (modeValid && $past(modeValid)) |-> txLaneData[p].b ==
        (isFourLane(pairSingleLane[p]) ? $past(txPortData[2*p].b) : $past(txPortData[2*p+1].a)))
      else $error("Transmit lane B carries the wrong port.");

    lane_b_rx_a: assert property (@(posedge clock) disable iff (!rst_n) // R05
      (modeValid && $past(modeValid) && !isFourLane(pairSingleLane[p])) |->
        (rxPortData[2*p+1].a == $past(rxLaneData[p].b) && rxPortData[2*p].b == qlps_pkg::IDLE_WORD))
      else $error("Receive lane B not delivered to the odd port.");

    lane_cd_tx_a: assert property (@(posedge clock) disable iff (!rst_n) // R06
      (modeValid && $past(modeValid)) |-> isFourLane(pairSingleLane[p]) ?
        (txLaneData[p].c == $past(txPortData[2*p].c) && txLaneData[p].d == $past(txPortData[2*p].d)) :
        (txLaneData[p].c == qlps_pkg::IDLE_WORD && txLaneData[p].d == qlps_pkg::IDLE_WORD))
      else $error("Transmit lanes C and D wrong for the mode.");

    lane_cd_rx_a: assert property (@(posedge clock) disable iff (!rst_n) // R07
      (modeValid && $past(modeValid) && isFourLane(pairSingleLane[p])) |->
        (rxPortData[2*p].c == $past(rxLaneData[p].c) && rxPortData[2*p].d == $past(rxLaneData[p].d)))
      else $error("Receive lanes C and D not delivered in four-lane mode.");

    odd_powered_a: assert property (@(posedge clock) disable iff (!rst_n) // R11
      modeValid |-> (port_power_down[2*p+1] == isFourLane(pairSingleLane[p]) && !port_power_down[2*p]))
      else $error("Odd port power state does not follow the mode.");

    odd_rx_idle_a: assert property (@(posedge clock) disable iff (!rst_n) // R11
      (modeValid && isFourLane(pairSingleLane[p])) |-> rxPortData[2*p+1] == qlps_pkg::IDLE_LANES)
      else $error("Odd port receives data in four-lane mode.");

    cd_rx_drop_a: assert property (@(posedge clock) disable iff (!rst_n) // R12
      (modeValid && !isFourLane(pairSingleLane[p])) |->
        (rxPortData[2*p].c == qlps_pkg::IDLE_WORD && rxPortData[2*p].d == qlps_pkg::IDLE_WORD))
      else $error("Receive lanes C and D not dropped in single-lane mode.");

    msb_order_a: assert property (@(posedge clock) disable iff (!rst_n) // R08
      (modeValid && $past(modeValid)) |->
        txLaneData[p].a[qlps_pkg::WORD_FIRST_BIT] == $past(txPortData[2*p].a[qlps_pkg::WORD_FIRST_BIT]))
      else $error("Lane word bit order broken.");
  end

  four_lane_c: cover property (@(posedge clock) disable iff (!rst_n)
    modeValid && !pairSingleLane[0]);
  single_lane_c: cover property (@(posedge clock) disable iff (!rst_n)
    modeValid && pairSingleLane[0]);
  mixed_pairs_c: cover property (@(posedge clock) disable iff (!rst_n)
    modeValid && pairSingleLane != '0 && pairSingleLane != '1);
  mode_taken_c: cover property (@(posedge clock) disable iff (!rst_n)
    $rose(modeValid));

endmodule

// ### quad_lane_port_steering_tb_top.sv
// Self-checking testbench for the quad lane port steering block.
`timescale 1ns/1ps
module quad_lane_port_steering_tb_top;
  logic                                            clock;
  logic                                            rst_n;
  logic [qlps_pkg::PAIR_COUNT-1:0]                 laneModeSel;
  qlps_pkg::qlps_lanes_t [qlps_pkg::PORT_COUNT-1:0] txPortData;
  qlps_pkg::qlps_lanes_t [qlps_pkg::PAIR_COUNT-1:0] rxLaneData;
  logic                                            modeValid;
  logic [qlps_pkg::PAIR_COUNT-1:0]                 pairSingleLane;
  logic [qlps_pkg::PORT_COUNT-1:0]                 portPowerDown;
  qlps_pkg::qlps_lanes_t [qlps_pkg::PAIR_COUNT-1:0] txLaneData;
  qlps_pkg::qlps_lanes_t [qlps_pkg::PORT_COUNT-1:0] rxPortData;
  int                                              errors;
  int                                              checks_done;

  qlps_quad_lane_port_steering uut (.clock(clock), .rst_n(rst_n), .lane_mode_select(laneModeSel),
    .txPortData(txPortData), .rxLaneData(rxLaneData), .modeValid(modeValid), .pairSingleLane(pairSingleLane),
    .port_power_down(portPowerDown), .txLaneData(txLaneData), .rxPortData(rxPortData));
  qlps_link_partner partner (.clock(clock), .rxLaneData(rxLaneData));

  // ---------------------------------------------------------------
  // Clock, compare and closing tasks
  // ---------------------------------------------------------------
  // Inputs move on the falling edge so the rising edge never races the drive.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic cmp_flags(string name, logic [7:0] expv, logic [7:0] got);
    checks_done++;
    if (got !== expv) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, expv, got);
    end
  endtask
  task automatic cmp_lanes(string name, qlps_pkg::qlps_lanes_t expv, qlps_pkg::qlps_lanes_t got);
    checks_done++;
    if (got !== expv) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, expv, got);
    end
  endtask
  task automatic end_sim();
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset, then check that the strap is taken at the tenth edge and never again.
  task automatic startup(logic [3:0] mode);
    logic [7:0] pwr;
    rst_n = 1'b0;
    laneModeSel = mode;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (10) @(negedge clock);
    cmp_flags("modeValid early", 8'h00, {7'h0, modeValid});
    cmp_flags("power early", 8'hFF, portPowerDown);
    @(negedge clock);
    for (int p = 0; p < 4; p++) pwr[2*p +: 2] = {~mode[p], 1'b0};
    cmp_flags("modeValid", 8'h01, {7'h0, modeValid});
    cmp_flags("pairSingleLane", {4'h0, mode}, {4'h0, pairSingleLane});
    cmp_flags("powerDown", pwr, portPowerDown);
    laneModeSel = ~mode;
    repeat (6) @(negedge clock);
    cmp_flags("mode after change", {4'h0, mode}, {4'h0, pairSingleLane});
  endtask
  // Stream distinct words every cycle and check each pair's steering against its mode.
  task automatic steering(logic [3:0] mode);
    qlps_pkg::qlps_lanes_t [7:0] txIn;
    qlps_pkg::qlps_lanes_t [3:0] rxIn;
    qlps_pkg::qlps_lanes_t       e;
    for (int c = 0; c < 6; c++) begin
      for (int q = 0; q < 8; q++) txPortData[q] = {8'(c*32+q*4), 8'(c*32+q*4+1), 8'(c*32+q*4+2), 8'(c*32+q*4+3)};
      if (c == 5) txPortData[0].a = 8'h80;
      @(posedge clock);
      txIn = txPortData;
      rxIn = rxLaneData;
      @(negedge clock);
      for (int p = 0; p < 4; p++) begin
        e = mode[p] ? {txIn[2*p].a, txIn[2*p+1].a, 16'h0000} : txIn[2*p];
        cmp_lanes("txLaneData", e, txLaneData[p]);
        e = mode[p] ? {rxIn[p].a, 24'h000000} : rxIn[p];
        cmp_lanes("rxPortData even", e, rxPortData[2*p]);
        e = mode[p] ? {rxIn[p].b, 24'h000000} : qlps_pkg::IDLE_LANES;
        cmp_lanes("rxPortData odd", e, rxPortData[2*p+1]);
      end
    end
    cmp_flags("msb first", 8'h01, {7'h0, txLaneData[0].a[0]});
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  // Two resets give every pair both modes; the second comes after the first steering stream has ended.
  initial begin
    errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    laneModeSel = 4'h0;
    txPortData = '0;
    @(negedge clock);
    startup(4'h5);
    steering(4'h5);
    startup(4'hA);
    steering(4'hA);
    end_sim();
  end
  // The run needs about 70 cycles; a hang is cut far beyond that.
  initial begin
    repeat (2000) @(posedge clock);
    errors++;
    end_sim();
  end
endmodule
